/* tprm_pkg.sv */
// tprm_pkg: offsets, field layout and reset values of the thermopile
// register bank.
// assumes a 64-location byte map reached through a 6-bit pointer.
package tprm_pkg;
   localparam int PTR_W = 6;
   localparam int OBJ_W = 17;
   localparam int AMB_W = 15;
   localparam int LP_W = 20;
   localparam int LP3_W = 16;
   localparam int FRZ_W = 24;
   localparam int FRZ_SHIFT = 4;
   localparam int MASK_W = 5;

   localparam logic [5:0] OFS_RSVD_ZERO = 6'h00;
   localparam logic [5:0] OFS_OBJ_HI = 6'h01;
   localparam logic [5:0] OFS_OBJ_MID = 6'h02;
   localparam logic [5:0] OFS_OBJ_AMB = 6'h03;
   localparam logic [5:0] OFS_AMB_LO = 6'h04;
   localparam logic [5:0] OFS_LP1_HI = 6'h05;
   localparam logic [5:0] OFS_LP1_MID = 6'h06;
   localparam logic [5:0] OFS_LP1_LP2 = 6'h07;
   localparam logic [5:0] OFS_LP2_MID = 6'h08;
   localparam logic [5:0] OFS_LP2_LO = 6'h09;
   localparam logic [5:0] OFS_LP3_HI = 6'h0a;
   localparam logic [5:0] OFS_LP3_LO = 6'h0b;
   localparam logic [5:0] OFS_FRZ_HI = 6'h0c;
   localparam logic [5:0] OFS_FRZ_MID = 6'h0d;
   localparam logic [5:0] OFS_FRZ_LO = 6'h0e;
   localparam logic [5:0] OFS_PRESENCE = 6'h0f;
   localparam logic [5:0] OFS_MOTION = 6'h10;
   localparam logic [5:0] OFS_SHOCK = 6'h11;
   localparam logic [5:0] OFS_INT_STATUS = 6'h12;
   localparam logic [5:0] OFS_CHIP_STATUS = 6'h13;
   localparam logic [5:0] OFS_FSEL_12 = 6'h14;
   localparam logic [5:0] OFS_FSEL_3 = 6'h15;
   localparam logic [5:0] OFS_TH_PRES = 6'h16;
   localparam logic [5:0] OFS_TH_MOT = 6'h17;
   localparam logic [5:0] OFS_TH_SHOCK = 6'h18;
   localparam logic [5:0] OFS_INT_MASK = 6'h19;
   localparam logic [5:0] OFS_DET_CFG = 6'h1a;
   localparam logic [5:0] OFS_TIMER = 6'h1b;
   localparam logic [5:0] OFS_OT_HI = 6'h1c;
   localparam logic [5:0] OFS_OT_LO = 6'h1d;
   localparam logic [5:0] OFS_RSVD_THIRTY = 6'h1e;
   localparam logic [5:0] OFS_NVM_CTRL = 6'h1f;
   localparam logic [5:0] OFS_NVM_FIRST = 6'h20;
   localparam logic [5:0] OFS_NVM_LAST = 6'h3e;
   localparam logic [5:0] OFS_BUS_ADDR = 6'h3f;

   // detection config field positions
   localparam int CFG_CYC_LSB = 0;
   localparam int CFG_SRC_LSB = 2;
   localparam int CFG_OTDIR_BIT = 4;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIB = 4'h0;
   localparam logic [15:0] RST_OT = 16'h0000;

   typedef struct packed {
      logic [OBJ_W-1:0] obj;
      logic [AMB_W-1:0] amb;
      logic [LP_W-1:0] lp1;
      logic [LP_W-1:0] lp2;
      logic [LP3_W-1:0] lp3;
      logic motion;
   } tprm_sample_s;

   typedef struct packed {
      logic [PTR_W-1:0] ptr;
      logic [7:0] rdata;
      logic rvalid;
      tprm_sample_s res;
      tprm_sample_s pnd;
      logic pend;
      logic [FRZ_W-1:0] frz;
      logic [7:0] pres;
      logic [7:0] mot;
      logic [7:0] shk;
      logic [7:0] chip;
      logic [7:0] ist;
      logic [3:0] sel1;
      logic [3:0] sel2;
      logic [3:0] sel3;
      logic [7:0] thp;
      logic [7:0] thm;
      logic [7:0] ths;
      logic [MASK_W-1:0] mask;
      logic [1:0] cyc;
      logic [1:0] src;
      logic otdir;
      logic [7:0] timer;
      logic [15:0] ott;
      logic [7:0] nvmc;
   } tprm_state_s;
endpackage : tprm_pkg

/* tprm_regs.sv */
// tprm_regs: register bank of the thermopile sensor, byte access by pointer.
// assumes the serial framing sits outside on the same clock and issues
// address-load, read-byte and write-byte pulses; results come from the
// signal path on the same clock, so no input is synchronised.
//
// Contract
// - raw object value, 17 bits read-only, at 1, 2 and bit 7 of 3.
// - ambient reference reading, 15 bits read-only, at 3[6:0] and 4.
// - two 20-bit filtered object values at 5..7[7:4] and 7[3:0]..9.
// - filtered ambient value, 16 bits read-only, at 10 and 11.
// - on motion, second filtered value frozen into 24 bits at 12..14.
// - presence magnitude at 15, its sign in chip status.
// - motion magnitude at 16, its sign in chip status.
// - three writable 4-bit filter selects at 20[3:0], 20[7:4], 21[3:0].
// - cycle time 26[1:0], source select 26[3:2], over-temp direction 26[4].
// - results read-only, controls read-write, locations 0 and 30 void.
// - reading interrupt status clears it and releases interrupt high unless an event lands in that cycle.
// - pointer increments per byte and wraps to zero after 63.
// - writes to non-writable locations change nothing.
module tprm_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // byte access from the serial framing
   input wire logic i_addr_load,
   input wire logic [7:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic i_xfer_active,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   // results from the signal path
   input wire logic i_sample_valid,
   input wire logic [16:0] i_object_raw,
   input wire logic [14:0] i_ambient_raw,
   input wire logic [19:0] i_object_filtered_first,
   input wire logic [19:0] i_object_filtered_second,
   input wire logic [15:0] i_ambient_filtered,
   input wire logic i_motion_detected,
   input wire logic [7:0] i_presence_value,
   input wire logic [7:0] i_motion_value,
   input wire logic [7:0] i_ambient_shock_value,
   input wire logic [7:0] i_chip_status,
   input wire logic [7:0] i_int_events,
   // nonvolatile memory window and bus address
   input wire logic [7:0] i_nvm_byte,
   input wire logic [7:0] i_bus_address,
   output logic [4:0] o_nvm_addr,
   // control values to the signal path
   output logic [3:0] o_filter_select_first,
   output logic [3:0] o_filter_select_second,
   output logic [3:0] o_filter_select_third,
   output logic [7:0] o_presence_threshold,
   output logic [7:0] o_motion_threshold,
   output logic [7:0] o_ambient_shock_threshold,
   output logic [4:0] o_interrupt_mask,
   output logic [1:0] o_motion_cycle_time,
   output logic [1:0] o_presence_source,
   output logic o_overtemp_direction,
   output logic [7:0] o_timer_interrupt_period,
   output logic [15:0] o_overtemp_threshold,
   output logic [7:0] o_nvm_control,
   output logic o_int_status_n
);
   tprm_pkg::tprm_state_s st_r;
   tprm_pkg::tprm_state_s st_nxt;
   tprm_pkg::tprm_sample_s smp;
   tprm_pkg::tprm_sample_s cur;
   logic clr_ist;

   function automatic logic [7:0] read_byte(
      input tprm_pkg::tprm_state_s s,
      input logic [7:0] nvm
   );
      logic [7:0] b;
      b = tprm_pkg::RST_BYTE;
      case (s.ptr)
         tprm_pkg::OFS_OBJ_HI: b = s.res.obj[16:9];
         tprm_pkg::OFS_OBJ_MID: b = s.res.obj[8:1];
         tprm_pkg::OFS_OBJ_AMB: b = {s.res.obj[0], s.res.amb[14:8]};
         tprm_pkg::OFS_AMB_LO: b = s.res.amb[7:0];
         tprm_pkg::OFS_LP1_HI: b = s.res.lp1[19:12];
         tprm_pkg::OFS_LP1_MID: b = s.res.lp1[11:4];
         tprm_pkg::OFS_LP1_LP2: b = {s.res.lp1[3:0], s.res.lp2[19:16]};
         tprm_pkg::OFS_LP2_MID: b = s.res.lp2[15:8];
         tprm_pkg::OFS_LP2_LO: b = s.res.lp2[7:0];
         tprm_pkg::OFS_LP3_HI: b = s.res.lp3[15:8];
         tprm_pkg::OFS_LP3_LO: b = s.res.lp3[7:0];
         tprm_pkg::OFS_FRZ_HI: b = s.frz[23:16];
         tprm_pkg::OFS_FRZ_MID: b = s.frz[15:8];
         tprm_pkg::OFS_FRZ_LO: b = s.frz[7:0];
         tprm_pkg::OFS_PRESENCE: b = s.pres;
         tprm_pkg::OFS_MOTION: b = s.mot;
         tprm_pkg::OFS_SHOCK: b = s.shk;
         tprm_pkg::OFS_INT_STATUS: b = s.ist;
         tprm_pkg::OFS_CHIP_STATUS: b = s.chip;
         tprm_pkg::OFS_FSEL_12: b = {s.sel2, s.sel1};
         tprm_pkg::OFS_FSEL_3: b = {tprm_pkg::RST_NIB, s.sel3};
         tprm_pkg::OFS_TH_PRES: b = s.thp;
         tprm_pkg::OFS_TH_MOT: b = s.thm;
         tprm_pkg::OFS_TH_SHOCK: b = s.ths;
         tprm_pkg::OFS_INT_MASK: b = {3'h0, s.mask};
         tprm_pkg::OFS_DET_CFG: b = {3'h0, s.otdir, s.src, s.cyc};
         tprm_pkg::OFS_TIMER: b = s.timer;
         tprm_pkg::OFS_OT_HI: b = s.ott[15:8];
         tprm_pkg::OFS_OT_LO: b = s.ott[7:0];
         tprm_pkg::OFS_NVM_CTRL: b = s.nvmc;
         tprm_pkg::OFS_BUS_ADDR: b = i_bus_address;
         default: begin
            // locations 0 and 30 fall here and read zero
            if (s.ptr >= tprm_pkg::OFS_NVM_FIRST &&
                s.ptr <= tprm_pkg::OFS_NVM_LAST) begin
               b = nvm;
            end else begin
               b = tprm_pkg::RST_BYTE;
            end
         end
      endcase
      return b;
   endfunction : read_byte

   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      clr_ist = 1'b0;
      smp.obj = i_object_raw;
      smp.amb = i_ambient_raw;
      smp.lp1 = i_object_filtered_first;
      smp.lp2 = i_object_filtered_second;
      smp.lp3 = i_ambient_filtered;
      smp.motion = i_motion_detected;
      cur = i_sample_valid ? smp : st_r.pnd;
      // address load wins over a byte strobe in the same cycle
      if (i_addr_load) begin
         st_nxt.ptr = i_addr[5:0];
      end else if (i_rd) begin
         st_nxt.rdata = read_byte(st_r, i_nvm_byte);
         st_nxt.rvalid = 1'b1;
         st_nxt.ptr = st_r.ptr + 6'h01;
         clr_ist = (st_r.ptr == tprm_pkg::OFS_INT_STATUS);
      end else if (i_wr) begin
         st_nxt.ptr = st_r.ptr + 6'h01;
         case (st_r.ptr)
            tprm_pkg::OFS_FSEL_12: begin
               st_nxt.sel1 = i_wdata[3:0];
               st_nxt.sel2 = i_wdata[7:4];
            end
            tprm_pkg::OFS_FSEL_3: st_nxt.sel3 = i_wdata[3:0];
            tprm_pkg::OFS_TH_PRES: st_nxt.thp = i_wdata;
            tprm_pkg::OFS_TH_MOT: st_nxt.thm = i_wdata;
            tprm_pkg::OFS_TH_SHOCK: st_nxt.ths = i_wdata;
            tprm_pkg::OFS_INT_MASK: st_nxt.mask = i_wdata[4:0];
            tprm_pkg::OFS_DET_CFG: begin
               st_nxt.cyc = i_wdata[tprm_pkg::CFG_CYC_LSB +: 2];
               st_nxt.src = i_wdata[tprm_pkg::CFG_SRC_LSB +: 2];
               st_nxt.otdir = i_wdata[tprm_pkg::CFG_OTDIR_BIT];
            end
            tprm_pkg::OFS_TIMER: st_nxt.timer = i_wdata;
            tprm_pkg::OFS_OT_HI: st_nxt.ott[15:8] = i_wdata;
            tprm_pkg::OFS_OT_LO: st_nxt.ott[7:0] = i_wdata;
            tprm_pkg::OFS_NVM_CTRL: st_nxt.nvmc = i_wdata;
            default: begin
               // results, status, reserved and memory window stay put
               st_nxt.ptr = st_r.ptr + 6'h01;
            end
         endcase
      end
      // an event in the clearing cycle survives the clear
      st_nxt.ist = (clr_ist ? tprm_pkg::RST_BYTE : st_r.ist) | i_int_events;
      if (i_sample_valid) begin
         st_nxt.pres = i_presence_value;
         st_nxt.mot = i_motion_value;
         st_nxt.shk = i_ambient_shock_value;
         st_nxt.chip = i_chip_status;
      end
      // multi-byte results wait while a transfer runs, so a burst
      // never mixes two samples; only the newest waiting one is kept
      if (i_sample_valid && i_xfer_active) begin
         st_nxt.pnd = smp;
         st_nxt.pend = 1'b1;
      end else if (!i_xfer_active && (i_sample_valid || st_r.pend)) begin
         st_nxt.res = cur;
         st_nxt.pend = 1'b0;
         if (cur.motion) begin
            st_nxt.frz = {cur.lp2, 4'h0};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_rvalid = st_r.rvalid;
   assign o_nvm_addr = st_r.ptr[4:0];
   assign o_filter_select_first = st_r.sel1;
   assign o_filter_select_second = st_r.sel2;
   assign o_filter_select_third = st_r.sel3;
   assign o_presence_threshold = st_r.thp;
   assign o_motion_threshold = st_r.thm;
   assign o_ambient_shock_threshold = st_r.ths;
   assign o_interrupt_mask = st_r.mask;
   assign o_motion_cycle_time = st_r.cyc;
   assign o_presence_source = st_r.src;
   assign o_overtemp_direction = st_r.otdir;
   assign o_timer_interrupt_period = st_r.timer;
   assign o_overtemp_threshold = st_r.ott;
   assign o_nvm_control = st_r.nvmc;
   assign o_int_status_n = ~|st_r.ist;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence rd_status_s;
      i_rd && !i_addr_load && st_r.ptr == tprm_pkg::OFS_INT_STATUS;
   endsequence

   sequence xfer_end_s;
      st_r.pend && !i_xfer_active;
   endsequence

   // controls gathered so one check covers every writable field
   logic [77:0] ctl_bits;
   assign ctl_bits = {st_r.sel1, st_r.sel2, st_r.sel3, st_r.thp, st_r.thm,
      st_r.ths, st_r.mask, st_r.cyc, st_r.src, st_r.otdir, st_r.timer,
      st_r.ott, st_r.nvmc};

   sequence rd_s;
      i_rd && !i_addr_load;
   endsequence

   sequence wr_s;
      i_wr && !i_addr_load && !i_rd;
   endsequence

   ptr_wrap_a: assert property (
      (i_rd || i_wr) && !i_addr_load && st_r.ptr == 6'h3f
      |=> st_r.ptr == 6'h00)
      else $error("pointer did not wrap to zero");

   ptr_step_a: assert property (
      (i_rd || i_wr) && !i_addr_load |=> st_r.ptr == $past(st_r.ptr) + 6'h01)
      else $error("pointer did not step by one");

   status_clear_a: assert property (
      rd_status_s ##0 (i_int_events == 8'h00) |=> st_r.ist == 8'h00 &&
      o_int_status_n)
      else $error("status read did not clear and release");

   set_wins_a: assert property (
      rd_status_s ##0 (i_int_events != 8'h00) |=>
      st_r.ist == $past(i_int_events) && !o_int_status_n)
      else $error("event lost in clearing read");

   read_data_a: assert property (
      i_rd && !i_addr_load && (st_r.ptr == tprm_pkg::OFS_RSVD_ZERO ||
      st_r.ptr == tprm_pkg::OFS_RSVD_THIRTY)
      |=> o_rvalid && o_rdata == 8'h00)
      else $error("reserved location did not read zero");

   ro_write_a: assert property (
      i_wr && !i_addr_load && !i_rd && !i_sample_valid && !st_r.pend &&
      st_r.ptr == tprm_pkg::OFS_OBJ_HI |=> $stable(st_r.res))
      else $error("write changed a read-only result");

   cfg_write_a: assert property (
      i_wr && !i_addr_load && !i_rd && st_r.ptr == tprm_pkg::OFS_DET_CFG
      |=> o_motion_cycle_time == $past(i_wdata[1:0]) &&
      o_presence_source == $past(i_wdata[3:2]) &&
      o_overtemp_direction == $past(i_wdata[4]))
      else $error("detection config not stored");

   burst_hold_a: assert property (
      i_xfer_active && $past(i_xfer_active) |-> $stable(st_r.res))
      else $error("result changed inside a transfer");

   pend_apply_a: assert property (
      xfer_end_s ##0 !i_sample_valid |=> st_r.res == $past(st_r.pnd) &&
      !st_r.pend)
      else $error("waiting sample not applied after transfer");

   freeze_a: assert property (
      i_sample_valid && !i_xfer_active && i_motion_detected
      |=> st_r.frz == {$past(i_object_filtered_second), 4'h0})
      else $error("frozen copy not captured on motion");

   rd_answer_a: assert property (
      rd_s |=> o_rvalid)
      else $error("read gave no data strobe");

   ptr_load_a: assert property (
      i_addr_load |=> st_r.ptr == $past(i_addr[5:0]))
      else $error("pointer not loaded from address byte");

   fsel_write_a: assert property (
      wr_s ##0 (st_r.ptr == tprm_pkg::OFS_FSEL_12) |=>
      o_filter_select_first == $past(i_wdata[3:0]) &&
      o_filter_select_second == $past(i_wdata[7:4]))
      else $error("filter selects not stored");

   ro_ctl_a: assert property (
      wr_s ##0 (st_r.ptr < tprm_pkg::OFS_FSEL_12 ||
      st_r.ptr == tprm_pkg::OFS_RSVD_THIRTY ||
      st_r.ptr > tprm_pkg::OFS_NVM_CTRL) |=> $stable(ctl_bits))
      else $error("write to a fixed location changed a control");

   ctl_idle_a: assert property (
      !i_wr || i_rd || i_addr_load |=> $stable(ctl_bits))
      else $error("control changed without a write");

   sample_take_a: assert property (
      i_sample_valid && !i_xfer_active |=> st_r.res == $past(smp) &&
      !st_r.pend)
      else $error("idle sample not applied at once");

   pend_take_a: assert property (
      i_sample_valid && i_xfer_active |=> st_r.pnd == $past(smp) &&
      st_r.pend)
      else $error("sample during transfer not held back");

   single_byte_a: assert property (
      i_sample_valid |=> st_r.pres == $past(i_presence_value) &&
      st_r.mot == $past(i_motion_value) &&
      st_r.chip == $past(i_chip_status))
      else $error("single-byte results not taken");

   frz_hold_a: assert property (
      i_xfer_active || (i_sample_valid && !i_motion_detected)
      |=> $stable(st_r.frz))
      else $error("frozen copy changed without motion");

   sticky_a: assert property (
      !(i_rd && !i_addr_load && st_r.ptr == tprm_pkg::OFS_INT_STATUS)
      |=> (st_r.ist & $past(st_r.ist)) == $past(st_r.ist))
      else $error("status bit dropped without a read");

   rsvd_bits_a: assert property (
      rd_s ##0 (st_r.ptr == tprm_pkg::OFS_FSEL_3) |=> o_rdata[7:4] == 4'h0)
      else $error("reserved filter select bits not zero");

   nvm_read_a: assert property (
      rd_s ##0 (st_r.ptr >= tprm_pkg::OFS_NVM_FIRST &&
      st_r.ptr <= tprm_pkg::OFS_NVM_LAST) |=> o_rdata == $past(i_nvm_byte))
      else $error("memory window byte not returned");
endmodule : tprm_regs

/* tprm_host.sv */
// tprm_host: host side of the register bank, giving byte access strobes.
// assumes the caller steps it from one clock; strobes change 1 ns after
// the rising edge and stay until the next operation replaces them.
module tprm_host (
   // clock
   input wire logic i_clk,
   // strobes to the register bank
   output logic o_addr_load,
   output logic [7:0] o_addr,
   output logic o_rd,
   output logic o_wr,
   output logic [7:0] o_wdata,
   output logic o_xfer_active
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_addr_load = 1'b0;
      o_addr = 8'h00;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wdata = 8'h00;
      o_xfer_active = 1'b0;
   end

   // one strobe set per cycle; controls are written before use
   task automatic op(input logic ld, rd, wr, input logic [7:0] a, d);
      @(posedge i_clk);
      #1;
      o_addr_load = ld;
      o_rd = rd;
      o_wr = wr;
      o_addr = a;
      o_wdata = d;
   endtask : op

   task automatic xfer(input logic v);
      @(posedge i_clk);
      #1;
      o_xfer_active = v;
   endtask : xfer
endmodule : tprm_host

/* testbench.sv */
// testbench: self-checking bench of the thermopile register bank.
// assumes tprm_regs and tprm_host compiled first; reads are queued as they
// are issued and compared when o_rvalid shows up.
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
   end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_nrst, i_addr_load, i_rd, i_wr, i_xfer_active;
   logic [7:0] i_addr, i_wdata, o_rdata, i_int_events, i_nvm_byte;
   logic o_rvalid, i_sample_valid, i_motion_detected, o_int_status_n;
   logic [16:0] i_object_raw;
   logic [14:0] i_ambient_raw;
   logic [19:0] i_object_filtered_first, i_object_filtered_second;
   logic [15:0] i_ambient_filtered, o_overtemp_threshold;
   logic [7:0] i_presence_value, i_motion_value, i_ambient_shock_value;
   logic [7:0] i_chip_status, o_nvm_control;
   logic [4:0] o_nvm_addr, o_interrupt_mask;
   logic [3:0] o_fs1, o_fs2, o_fs3;
   logic [1:0] o_motion_cycle_time, o_presence_source;
   logic o_overtemp_direction;
   logic [7:0] o_pth, o_mth, o_sth, o_tip;
   logic [23:0] frz = 24'h000000;
   logic [15:0] seed = 16'h0050;
   logic [7:0] cv [20:31];
   logic [7:0] expq [$];
   int n_mismatch = 0;
   int checks = 0;

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // memory window answers with its own index so each byte is distinct
   assign i_nvm_byte = {3'h5, o_nvm_addr};

   tprm_host tprm_host_i (.i_clk(i_clk), .o_addr_load(i_addr_load),
      .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata),
      .o_xfer_active(i_xfer_active));
   tprm_regs tprm_regs_i (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_addr_load(i_addr_load), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
      .i_wdata(i_wdata), .i_xfer_active(i_xfer_active), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid), .i_sample_valid(i_sample_valid),
      .i_object_raw(i_object_raw), .i_ambient_raw(i_ambient_raw),
      .i_object_filtered_first(i_object_filtered_first),
      .i_object_filtered_second(i_object_filtered_second),
      .i_ambient_filtered(i_ambient_filtered),
      .i_motion_detected(i_motion_detected),
      .i_presence_value(i_presence_value), .i_motion_value(i_motion_value),
      .i_ambient_shock_value(i_ambient_shock_value),
      .i_chip_status(i_chip_status), .i_int_events(i_int_events),
      .i_nvm_byte(i_nvm_byte), .i_bus_address(8'h5a),
      .o_nvm_addr(o_nvm_addr), .o_filter_select_first(o_fs1),
      .o_filter_select_second(o_fs2), .o_filter_select_third(o_fs3),
      .o_presence_threshold(o_pth), .o_motion_threshold(o_mth),
      .o_ambient_shock_threshold(o_sth), .o_interrupt_mask(o_interrupt_mask),
      .o_motion_cycle_time(o_motion_cycle_time),
      .o_presence_source(o_presence_source),
      .o_overtemp_direction(o_overtemp_direction),
      .o_timer_interrupt_period(o_tip),
      .o_overtemp_threshold(o_overtemp_threshold),
      .o_nvm_control(o_nvm_control), .o_int_status_n(o_int_status_n));

   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction : rnd

   function automatic logic [7:0] expv(input logic [5:0] a);
      case (a)
         6'h01: return i_object_raw[16:9];
         6'h02: return i_object_raw[8:1];
         6'h03: return {i_object_raw[0], i_ambient_raw[14:8]};
         6'h04: return i_ambient_raw[7:0];
         6'h05: return i_object_filtered_first[19:12];
         6'h06: return i_object_filtered_first[11:4];
         6'h07: return {i_object_filtered_first[3:0],
            i_object_filtered_second[19:16]};
         6'h08: return i_object_filtered_second[15:8];
         6'h09: return i_object_filtered_second[7:0];
         6'h0a: return i_ambient_filtered[15:8];
         6'h0b: return i_ambient_filtered[7:0];
         6'h0c: return frz[23:16];
         6'h0d: return frz[15:8];
         6'h0e: return frz[7:0];
         6'h0f: return i_presence_value;
         6'h10: return i_motion_value;
         6'h11: return i_ambient_shock_value;
         6'h13: return i_chip_status;
         6'h3f: return 8'h5a;
         default: return (a >= 6'h20) ? {3'h5, a[4:0]} : 8'h00;
      endcase
   endfunction : expv

   function automatic logic [7:0] cmask(input int a);
      case (a)
         21: return 8'h0f;
         25, 26: return 8'h1f;
         30: return 8'h00;
         default: return 8'hff;
      endcase
   endfunction : cmask

   task automatic ld(input logic [7:0] a);
      tprm_host_i.op(1'b1, 1'b0, 1'b0, a, 8'h00);
   endtask : ld
   task automatic rd(input logic [7:0] e);
      expq.push_back(e);
      tprm_host_i.op(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
   endtask : rd
   task automatic wr(input logic [7:0] d);
      tprm_host_i.op(1'b0, 1'b0, 1'b1, 8'h00, d);
   endtask : wr
   task automatic idle(input int n);
      tprm_host_i.op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : idle

   task automatic sample(input logic mot);
      // a strobe left standing would repeat its access every cycle
      tprm_host_i.op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      @(posedge i_clk);
      #1;
      i_object_raw = 17'({rnd(), rnd(), rnd()});
      i_ambient_raw = 15'({rnd(), rnd()});
      i_object_filtered_first = 20'({rnd(), rnd(), rnd()});
      i_object_filtered_second = 20'({rnd(), rnd(), rnd()});
      i_ambient_filtered = {rnd(), rnd()};
      i_presence_value = rnd();
      i_motion_value = rnd();
      i_ambient_shock_value = rnd();
      i_chip_status = rnd();
      i_motion_detected = mot;
      i_sample_valid = 1'b1;
      @(posedge i_clk);
      #1;
      i_sample_valid = 1'b0;
      i_motion_detected = 1'b0;
      if (mot) begin
         frz = {i_object_filtered_second, 4'h0};
      end
   endtask : sample

   task automatic end_sim();
      if (expq.size() != 0) begin
         n_mismatch++;
      end
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   always @(negedge i_clk) begin : mon
      logic [7:0] e;
      if (o_rvalid === 1'b1) begin
         if (expq.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] t=%0t unexpected read data", $time);
         end else begin
            e = expq.pop_front();
            `CHK(o_rdata, e)
         end
      end
   end

   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      logic [7:0] e2;
      i_nrst = 1'b0;
      i_sample_valid = 1'b0;
      i_motion_detected = 1'b0;
      i_int_events = 8'h00;
      {i_object_raw, i_ambient_raw, i_object_filtered_first} = '0;
      {i_object_filtered_second, i_ambient_filtered, i_chip_status} = '0;
      {i_presence_value, i_motion_value, i_ambient_shock_value} = '0;
      repeat (8) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      `CHK(o_int_status_n, 1'b1)
      ld(8'h14);
      for (int a = 20; a < 32; a++) begin
         cv[a] = rnd();
         wr(cv[a]);
      end
      ld(8'h14);
      for (int a = 20; a < 32; a++) rd(cv[a] & cmask(a));
      idle(2);
      `CHK(o_fs1, cv[20][3:0])
      `CHK(o_fs2, cv[20][7:4])
      `CHK(o_fs3, cv[21][3:0])
      `CHK(o_motion_cycle_time, cv[26][1:0])
      `CHK(o_presence_source, cv[26][3:2])
      `CHK(o_overtemp_direction, cv[26][4])
      `CHK(o_interrupt_mask, cv[25][4:0])
      `CHK(o_overtemp_threshold, {cv[28], cv[29]})
      `CHK(o_nvm_control, cv[31])
      `CHK(o_pth, cv[22])
      `CHK(o_mth, cv[23])
      `CHK(o_sth, cv[24])
      `CHK(o_tip, cv[27])
      $display("test controls done");
      sample(1'b1);
      idle(1);
      ld(8'h00);
      for (int a = 0; a < 20; a++) rd(expv(6'(a)));
      ld(8'h00);
      for (int a = 0; a < 20; a++) wr(rnd());
      ld(8'h00);
      for (int a = 0; a < 20; a++) rd(expv(6'(a)));
      sample(1'b0);
      idle(1);
      ld(8'h0c);
      for (int a = 12; a < 17; a++) rd(expv(6'(a)));
      ld(8'hfe);
      for (int a = 62; a < 66; a++) rd(expv(6'(a)));
      idle(2);
      $display("test results done");
      tprm_host_i.xfer(1'b1);
      ld(8'h01);
      rd(expv(6'h01));
      e2 = expv(6'h02);
      sample(1'b0);
      rd(e2);
      idle(1);
      tprm_host_i.xfer(1'b0);
      idle(2);
      ld(8'h01);
      rd(expv(6'h01));
      rd(expv(6'h02));
      idle(2);
      $display("test coherency done");
      i_int_events = 8'ha5;
      @(posedge i_clk);
      #1;
      i_int_events = 8'h00;
      @(posedge i_clk);
      #1;
      `CHK(o_int_status_n, 1'b0)
      ld(8'h12);
      rd(8'ha5);
      idle(3);
      `CHK(o_int_status_n, 1'b1)
      ld(8'h12);
      rd(8'h00);
      i_int_events = 8'h3c;
      tprm_host_i.op(1'b1, 1'b0, 1'b0, 8'h12, 8'h00);
      i_int_events = 8'h00;
      `CHK(o_int_status_n, 1'b0)
      rd(8'h3c);
      idle(4);
      $display("test interrupt done");
      end_sim();
   end
endmodule : testbench
